/* src/isc_slave_ctrl.v */
// I2C slave controller: control register, flags, interrupt and bus engine
//
// Contract
// - soft-reset bit 7 holds every engine state machine idle until cleared
// - soft-reset also clears the slave address register, enable included
// - bit 6 lets the address-match flag raise the slave interrupt
// - bit 5 lets the stop flag raise the slave interrupt
// - bit 4 lets the repeated-start flag raise the slave interrupt
// - bit 1 enables clock stretching; cleared, SCL is never held low
// - with stretching, a byte written before the stretch is not loaded
// - bit 0 enables the spike filter on SDA and SCL; clear passes inputs
// - read bit 0 shows transmit direction; written bit 0 is filter enable
// - receive-byte flag sets when a whole byte is ready in the data register
// - overrun: NACK without stretching, else hold SCL low until flag clears
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "isc_consts.vh"
module isc_slave_ctrl #(
   parameter FILT_CYC = `ISC_FILT_CYC
) (
   // system
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [11:0] adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire        ack_o,
   // interrupt
   output wire        irq_o,
   // i2c pins, open drain
   input  wire        scl_i,
   output wire        scl_o,
   output wire        scl_oe_o,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_o
);
   localparam S_IDLE   = 4'h0;
   localparam S_ADDR   = 4'h1;
   localparam S_AACK   = 4'h2;
   localparam S_RX     = 4'h3;
   localparam S_RACK   = 4'h4;
   localparam S_RSTR   = 4'h5;
   localparam S_TX     = 4'h6;
   localparam S_TACK   = 4'h7;
   localparam S_TSTR   = 4'h8;
   localparam S_WAIT   = 4'h9;

   function hit;
      input [11:0] adr;
      input [9:0]  idx;
      begin
         hit = (adr[11:2] == idx) && (adr[1:0] == 2'h0);
      end
   endfunction

   // hardware set wins over a software clear in the same cycle
   function [7:0] sticky;
      input [7:0] old;
      input [7:0] set;
      input [7:0] clr;
      begin
         sticky = (old & ~clr) | set;
      end
   endfunction

   // registers
   reg [7:0]  con_reg;
   reg [7:0]  adr_reg;
   reg [7:0]  flag_reg;
   reg [7:0]  txbuf_reg;
   reg [7:0]  rxdat_reg;
   reg        ack_reg;
   reg [31:0] dat_reg;
   reg        irq_reg;
   // engine
   reg [3:0]  st_reg;
   reg [2:0]  bit_reg;
   reg [7:0]  sh_reg;
   reg        xmt_reg;
   reg        busy_reg;
   reg        sda_drv_reg;
   reg        scl_drv_reg;
   reg        mack_reg;
   reg        byte_reg;
   reg        scl_d_reg;
   reg        sda_d_reg;
   reg [7:0]  flag_set;

   wire       scl_f;
   wire       sda_f;
   wire       srst     = con_reg[`ISC_CON_SRST];
   wire       stretch  = con_reg[`ISC_CON_STRETCH];
   wire       req      = cyc_i & stb_i;
   wire       wr_acc   = req & ack_reg & we_i & sel_i[0];
   wire       wr_con   = wr_acc & hit(adr_i, `ISC_IDX_CON);
   wire       wr_adr   = wr_acc & hit(adr_i, `ISC_IDX_ADDR);
   wire       wr_stat  = wr_acc & hit(adr_i, `ISC_IDX_STAT);
   wire       wr_data  = wr_acc & hit(adr_i, `ISC_IDX_DATA);
   wire       scl_rise = scl_f & ~scl_d_reg;
   wire       scl_fall = ~scl_f & scl_d_reg;
   wire       start_c  = scl_f & scl_d_reg & ~sda_f & sda_d_reg;
   wire       stop_c   = scl_f & scl_d_reg & sda_f & ~sda_d_reg;
   wire [7:0] flag_clr = wr_stat ? dat_i[7:0] : 8'h00;
   wire       rx_full  = flag_reg[`ISC_F_RXB];
   wire [7:0] rd_con   = {3'h0, busy_reg, 3'h0, xmt_reg};

   assign ack_o    = ack_reg;
   assign dat_o    = dat_reg;
   assign irq_o    = irq_reg;
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = scl_drv_reg;
   assign sda_oe_o = sda_drv_reg;

   isc_pin_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .en_i  (con_reg[`ISC_CON_FILT]),
      .pin_i (scl_i),
      .pin_o (scl_f)
   );

   isc_pin_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .en_i  (con_reg[`ISC_CON_FILT]),
      .pin_i (sda_i),
      .pin_o (sda_f)
   );

   // wishbone: ack one cycle after the request, read data sampled with it
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_reg <= req & ~ack_reg;
         if (req & ~ack_reg & ~we_i) begin
            if (hit(adr_i, `ISC_IDX_CON))
               dat_reg <= {24'h00_0000, rd_con};
            else if (hit(adr_i, `ISC_IDX_ADDR))
               dat_reg <= {24'h00_0000, adr_reg};
            else if (hit(adr_i, `ISC_IDX_STAT))
               dat_reg <= {24'h00_0000, flag_reg};
            else if (hit(adr_i, `ISC_IDX_DATA))
               dat_reg <= {24'h00_0000, rxdat_reg};
            else
               dat_reg <= 32'h0000_0000;
         end
      end
   end

   // software registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         con_reg   <= `ISC_CON_RST;
         adr_reg   <= `ISC_ADDR_RST;
         txbuf_reg <= 8'h00;
      end else if (ce_i) begin
         if (wr_con)
            con_reg <= dat_i[7:0];
         if (srst)
            adr_reg <= `ISC_ADDR_RST;
         else if (wr_adr)
            adr_reg <= dat_i[7:0];
         if (wr_data)
            txbuf_reg <= dat_i[7:0];
      end
   end

   // flags and interrupt
   always @(posedge clk_i) begin
      if (rst_i) begin
         flag_reg <= `ISC_STAT_RST;
         irq_reg  <= 1'b0;
      end else if (ce_i) begin
         if (srst) begin
            flag_reg <= `ISC_STAT_RST;
         end else begin
            flag_reg <= sticky(flag_reg, flag_set,
                               flag_clr | (wr_data ? 8'h08 : 8'h00)) & `ISC_IRQ_MASK;
         end
         // enables sit at the same bit positions as the flags
         irq_reg <= |(flag_reg & con_reg & `ISC_IRQ_MASK);
      end
   end

   // bus engine
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_reg      <= S_IDLE;
         bit_reg     <= 3'h0;
         sh_reg      <= 8'h00;
         xmt_reg     <= 1'b0;
         busy_reg    <= 1'b0;
         sda_drv_reg <= 1'b0;
         scl_drv_reg <= 1'b0;
         mack_reg    <= 1'b0;
         byte_reg    <= 1'b0;
         scl_d_reg   <= 1'b1;
         sda_d_reg   <= 1'b1;
         rxdat_reg   <= 8'h00;
         flag_set    <= 8'h00;
      end else if (ce_i) begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
         flag_set  <= 8'h00;
         if (srst) begin
            st_reg      <= S_IDLE;
            bit_reg     <= 3'h0;
            xmt_reg     <= 1'b0;
            busy_reg    <= 1'b0;
            sda_drv_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
         end else if (stop_c) begin
            if (st_reg != S_IDLE && st_reg != S_WAIT)
               flag_set[`ISC_F_STOP] <= 1'b1;
            st_reg      <= S_IDLE;
            busy_reg    <= 1'b0;
            sda_drv_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
         end else if (start_c) begin
            if (busy_reg)
               flag_set[`ISC_F_RSTART] <= 1'b1;
            busy_reg    <= 1'b1;
            st_reg      <= S_ADDR;
            byte_reg    <= 1'b0;
            bit_reg     <= 3'h0;
            sda_drv_reg <= 1'b0;
            scl_drv_reg <= 1'b0;
         end else begin
            case (st_reg)
               S_ADDR, S_RX: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda_f};
                     bit_reg <= bit_reg + 3'h1;
                     byte_reg <= (bit_reg == 3'h7);
                  end else if (scl_fall && byte_reg && st_reg == S_ADDR) begin
                     if (adr_reg[`ISC_ADR_EN] && sh_reg[7:1] == adr_reg[6:0]) begin
                        flag_set[`ISC_F_ADDR] <= 1'b1;
                        xmt_reg     <= sh_reg[0];
                        sda_drv_reg <= 1'b1;
                        st_reg      <= S_AACK;
                     end else begin
                        st_reg <= S_WAIT;
                     end
                  end else if (scl_fall && byte_reg) begin
                     if (!rx_full) begin
                        rxdat_reg             <= sh_reg;
                        flag_set[`ISC_F_RXB] <= 1'b1;
                        sda_drv_reg           <= 1'b1;
                        st_reg                <= S_RACK;
                     end else if (stretch) begin
                        scl_drv_reg <= 1'b1;
                        st_reg      <= S_RSTR;
                     end else begin
                        // overrun without stretching: byte dropped, no ack
                        st_reg <= S_WAIT;
                     end
                  end
               end
               S_RSTR: begin
                  // hold SCL low until software clears the receive-byte flag
                  if (!rx_full) begin
                     rxdat_reg             <= sh_reg;
                     flag_set[`ISC_F_RXB] <= 1'b1;
                     sda_drv_reg           <= 1'b1;
                     scl_drv_reg           <= 1'b0;
                     st_reg                <= S_RACK;
                  end
               end
               S_AACK, S_RACK: begin
                  if (scl_fall) begin
                     sda_drv_reg <= 1'b0;
                     bit_reg     <= 3'h0;
                     if (st_reg == S_AACK && xmt_reg) begin
                        if (stretch) begin
                           // a byte written before the stretch is not used
                           flag_set[`ISC_F_TXB] <= 1'b1;
                           scl_drv_reg          <= 1'b1;
                           st_reg               <= S_TSTR;
                        end else begin
                           sh_reg               <= txbuf_reg;
                           sda_drv_reg          <= ~txbuf_reg[7];
                           flag_set[`ISC_F_TXB] <= 1'b1;
                           st_reg               <= S_TX;
                        end
                     end else begin
                        st_reg <= S_RX;
                     end
                  end
               end
               S_TSTR: begin
                  // only a write made during the stretch is shifted out
                  if (wr_data) begin
                     sh_reg      <= dat_i[7:0];
                     sda_drv_reg <= ~dat_i[7];
                     scl_drv_reg <= 1'b0;
                     st_reg      <= S_TX;
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     bit_reg <= bit_reg + 3'h1;
                     if (bit_reg == 3'h7) begin
                        sda_drv_reg <= 1'b0;
                        st_reg      <= S_TACK;
                     end else begin
                        sh_reg      <= {sh_reg[6:0], 1'b0};
                        sda_drv_reg <= ~sh_reg[6];
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise) begin
                     mack_reg <= ~sda_f;
                  end else if (scl_fall) begin
                     bit_reg <= 3'h0;
                     if (!mack_reg) begin
                        // master nack ends the data; release for stop or restart
                        st_reg <= S_WAIT;
                     end else if (stretch) begin
                        flag_set[`ISC_F_TXB] <= 1'b1;
                        scl_drv_reg          <= 1'b1;
                        st_reg               <= S_TSTR;
                     end else begin
                        // no stretching: the old byte goes out if none was written
                        sh_reg               <= txbuf_reg;
                        sda_drv_reg          <= ~txbuf_reg[7];
                        flag_set[`ISC_F_TXB] <= 1'b1;
                        st_reg               <= S_TX;
                     end
                  end
               end
               S_WAIT, S_IDLE: begin
                  sda_drv_reg <= 1'b0;
                  scl_drv_reg <= 1'b0;
               end
               default: begin
                  st_reg <= S_IDLE;
               end
            endcase
            // stretching switched off must release a held clock at once
            if (!stretch && (st_reg == S_RSTR || st_reg == S_TSTR)) begin
               scl_drv_reg <= 1'b0;
               st_reg      <= S_WAIT;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* common/isc_consts.vh */
// register map, field positions and timing constants of the slave controller
`ifndef ISC_CONSTS_VH
`define ISC_CONSTS_VH

// register indices; byte address is four times the index
`define ISC_IDX_ADDR      10'h0DA
`define ISC_IDX_CON       10'h0DB
`define ISC_IDX_STAT      10'h0DC
`define ISC_IDX_DATA      10'h0DD

// reset values
`define ISC_CON_RST       8'h00
`define ISC_ADDR_RST      8'h00
`define ISC_STAT_RST      8'h00

// control register fields
`define ISC_CON_SRST      7
`define ISC_CON_STRETCH   1
`define ISC_CON_FILT      0
`define ISC_RD_BUSY       4
`define ISC_RD_XMT        0
`define ISC_IRQ_MASK      8'h7C

// status flags, same positions as their enables
`define ISC_F_ADDR        6
`define ISC_F_STOP        5
`define ISC_F_RSTART      4
`define ISC_F_TXB         3
`define ISC_F_RXB         2

// address register enable bit
`define ISC_ADR_EN        7

// timing
`define ISC_CLK_NS        100
`define ISC_FILT_NS       50
`define ISC_FILT_CYC      (((`ISC_FILT_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS) < 1 ? 1 : \
                           ((`ISC_FILT_NS + `ISC_CLK_NS - 1) / `ISC_CLK_NS))

`endif

/* src/isc_pin_filter.v */
// two-flop synchroniser and optional spike filter for one bus input
`timescale 1ns/1ps
`default_nettype none
module isc_pin_filter #(
   parameter FILT_CYC = 1
) (
   // clock and control
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       ce_i,
   input  wire       en_i,
   // pin
   input  wire       pin_i,
   output wire       pin_o
);
   reg       sync1_reg;
   reg       sync2_reg;
   reg       out_reg;
   reg [3:0] cnt_reg;

   assign pin_o = out_reg;

   // lines idle high, so reset to one to avoid a false start
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         out_reg   <= 1'b1;
         cnt_reg   <= 4'h0;
      end else if (ce_i) begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
         if (!en_i) begin
            out_reg <= sync2_reg;
            cnt_reg <= 4'h0;
         end else if (sync2_reg == out_reg) begin
            cnt_reg <= 4'h0;
         end else if (cnt_reg >= FILT_CYC[3:0]) begin
            // a level must persist past the spike width before it is passed
            out_reg <= sync2_reg;
            cnt_reg <= 4'h0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/isc_slave_ctrl_checker.sv */
// concurrent checks on the slave controller's bus, interrupt and pin outputs
`timescale 1ns/1ps
`default_nettype none
module isc_slave_ctrl_checker (
   // system
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // wishbone
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [11:0] adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // interrupt and pins
   input wire logic        irq_o,
   input wire logic        scl_i,
   input wire logic        scl_o,
   input wire logic        scl_oe_o,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o
);
   logic       srst_q;
   logic       strch_q;
   logic [4:0] en_q;
   wire        con_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 12'h36C;
   // shadow of the control bits, taken at the edge where the write lands
   always @(posedge clk_i) begin
      if (rst_i) begin
         srst_q  <= 1'b0;
         strch_q <= 1'b0;
         en_q    <= 5'h00;
      end else if (con_wr && ce_i) begin
         srst_q  <= dat_i[7];
         strch_q <= dat_i[1];
         en_q    <= dat_i[6:2];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_srst_held;
      srst_q [*3];
   endsequence
   sequence s_no_stretch;
      !strch_q [*3];
   endsequence
   sequence s_mask_off;
      (en_q == 5'h00) [*3];
   endsequence
   chk_ack_answer: assert property ((s_req and ce_i) |=> ack_o)
      else $error("no ack one cycle after request");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   chk_unmapped_zero: assert property ((s_req and (!we_i && adr_i == 12'h000)) |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_srst_addr: assert property ((s_req and (srst_q && !we_i && adr_i == 12'h368))
      |=> dat_o[7:0] == 8'h00) else $error("address register survives soft reset");
   chk_srst_quiet: assert property (s_srst_held |-> !sda_oe_o && !scl_oe_o)
      else $error("pins driven during soft reset");
   chk_srst_irq: assert property (s_srst_held |-> !irq_o)
      else $error("interrupt during soft reset");
   chk_stretch_off: assert property (s_no_stretch |-> !scl_oe_o)
      else $error("scl held low with stretching off");
   chk_irq_masked: assert property (s_mask_off |-> !irq_o)
      else $error("interrupt with all enables clear");
   chk_irq_cause: assert property ($rose(irq_o) |-> (en_q | $past(en_q)) != 5'h00)
      else $error("interrupt rose without enable");
endmodule
bind isc_slave_ctrl isc_slave_ctrl_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

/* bench/isc_i2c_master.sv */
// behavioural bus master on the far side of the slave's pins
`timescale 1ns/1ps
`default_nettype none
module isc_i2c_master #(
   parameter int HALF = 800
) (
   // pulls, high drags the line low
   output var logic scl_pull_o = 1'b0,
   output var logic sda_pull_o = 1'b0,
   // resolved lines
   input wire logic scl_i,
   input wire logic sda_i
);
   // phases of eight system clocks so the sync and filter pipeline keeps up
   task automatic rise();
      int n;
      n = 0;
      scl_pull_o = 1'b0;
      // a stretching slave keeps scl low; the wait is capped
      while (scl_i !== 1'b1 && n < 4000) begin
         #10;
         n++;
      end
   endtask
   task automatic bit_x(input logic b, output logic r);
      #(HALF / 4) sda_pull_o = ~b;
      #(HALF * 3 / 4) rise();
      #(HALF / 2) r = sda_i;
      #(HALF / 2) scl_pull_o = 1'b1;
   endtask
   task automatic start();
      #(HALF / 4) sda_pull_o = 1'b0;
      #(HALF * 3 / 4) rise();
      #(HALF) sda_pull_o = 1'b1;
      #(HALF) scl_pull_o = 1'b1;
   endtask
   task automatic stop();
      #(HALF / 4) sda_pull_o = 1'b1;
      #(HALF * 3 / 4) rise();
      #(HALF) sda_pull_o = 1'b0;
      #(HALF);
   endtask
   // a low glitch on sda shorter than the filter window, idle bus
   task automatic spike();
      #30 sda_pull_o = 1'b1;
      #40 sda_pull_o = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, nak);
   endtask
   task automatic recv(input logic nak, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nak, r);
   endtask
endmodule
`default_nettype wire

/* bench/isc_slave_ctrl_test.sv */
// self-checking bench for the slave controller's registers and bus engine
`timescale 1ns/1ps
`default_nettype none
`include "isc_consts.vh"
module isc_slave_ctrl_test;
   localparam logic [11:0] A_ADR = {`ISC_IDX_ADDR, 2'b00};
   localparam logic [11:0] A_CON = {`ISC_IDX_CON, 2'b00};
   localparam logic [11:0] A_ST  = {`ISC_IDX_STAT, 2'b00};
   localparam logic [11:0] A_DAT = {`ISC_IDX_DATA, 2'b00};
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i  = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [11:0] adr_i = 12'h000;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   wire  [31:0] dat_o;
   wire         ack_o, irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, scl_pull, sda_pull;
   wire         scl_w = ~(scl_pull | (scl_oe_o & ~scl_o));
   wire         sda_w = ~(sda_pull | (sda_oe_o & ~sda_o));
   int          err_total = 0;
   int          samples_checked = 0;
   logic [7:0]  q;
   logic [7:0]  d;
   logic        nak;
   always #50 clk_i = ~clk_i;
   isc_slave_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
   isc_i2c_master mst_u (.scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .scl_i(scl_w),
      .sda_i(sda_w));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] v,
                     output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {24'h0, v};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      r = dat_o[7:0];
      chk("ack", ack_o, 8'h01);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      logic [7:0] x;
      wb(1'b1, a, v, x);
   endtask
   task automatic rd(input logic [11:0] a, output logic [7:0] v);
      wb(1'b0, a, 8'h00, v);
   endtask
   task automatic addr(input logic rnw, input logic exp_nak);
      mst_u.start();
      mst_u.send({7'h2A, rnw}, nak);
      chk("addr_ack", nak, {7'h0, exp_nak});
   endtask
   task automatic wait_str();
      int n;
      n = 0;
      while (scl_oe_o !== 1'b1 && n < 400) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #(3_000_000);
      err_total++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(A_CON, q);
      chk("con_rst", q, 8'h00);
      rd(A_ST, q);
      chk("stat_rst", q, 8'h00);
      wr(12'h000, 8'hFF);
      rd(12'h000, q);
      chk("unmapped", q, 8'h00);
      chk("irq_rst", irq_o, 8'h00);
      // clock enable low: a pending request must not be answered
      ce_i <= 1'b0;
      fork
         wr(A_ADR, 8'h55);
         begin
            repeat (6) @(posedge clk_i);
            chk("ce_freeze", ack_o, 8'h00);
            ce_i <= 1'b1;
         end
      join
      rd(A_ADR, q);
      chk("ce_resume", q, 8'h55);
      $display("test reset done");
      wr(A_ADR, 8'hAA);
      wr(A_CON, 8'h7C);
      addr(1'b0, 1'b0);
      mst_u.send(8'hA5, nak);
      chk("rx_ack", nak, 8'h00);
      addr(1'b0, 1'b0);
      mst_u.stop();
      rd(A_ST, q);
      chk("flags", q, 8'h74);
      rd(A_DAT, q);
      chk("rx_data", q, 8'hA5);
      chk("irq_all", irq_o, 8'h01);
      // one enable at a time: only bits whose flag is set may raise the line
      for (int i = 2; i <= 6; i++) begin
         wr(A_CON, 8'h01 << i);
         repeat (2) @(posedge clk_i);
         chk("irq_gate", irq_o, (8'h74 >> i) & 8'h01);
      end
      wr(A_ST, 8'h7C);
      rd(A_ST, q);
      chk("stat_clr", q, 8'h00);
      $display("test flags done");
      wr(A_CON, 8'h04);
      addr(1'b0, 1'b0);
      mst_u.send(8'h11, nak);
      chk("first_ack", nak, 8'h00);
      mst_u.send(8'h22, nak);
      chk("overrun_nak", nak, 8'h01);
      mst_u.stop();
      wr(A_ST, 8'h7C);
      wr(A_CON, 8'h06);
      addr(1'b0, 1'b0);
      mst_u.send(8'h33, nak);
      fork
         mst_u.send(8'h44, nak);
         begin
            wait_str();
            chk("stretch_hold", scl_oe_o, 8'h01);
            wr(A_ST, 8'h04);
         end
      join
      chk("stretch_ack", nak, 8'h00);
      mst_u.stop();
      rd(A_DAT, q);
      chk("late_data", q, 8'h44);
      wr(A_ST, 8'h7C);
      $display("test overrun done");
      wr(A_CON, 8'h0A);
      wr(A_DAT, 8'h11);
      addr(1'b1, 1'b0);
      fork
         mst_u.recv(1'b1, d);
         begin
            wait_str();
            rd(A_CON, q);
            chk("direction", q & 8'h01, 8'h01);
            rd(A_ST, q);
            chk("tx_flag", q & 8'h08, 8'h08);
            chk("tx_irq", irq_o, 8'h01);
            wr(A_DAT, 8'h3C);
         end
      join
      chk("tx_byte", d, 8'h3C);
      mst_u.stop();
      wr(A_ST, 8'h7C);
      $display("test transmit done");
      wr(A_CON, 8'h01);
      addr(1'b0, 1'b0);
      mst_u.send(8'h5A, nak);
      chk("filt_ack", nak, 8'h00);
      mst_u.stop();
      rd(A_DAT, q);
      chk("filt_data", q, 8'h5A);
      wr(A_ST, 8'h7C);
      @(negedge clk_i);
      mst_u.spike();
      repeat (8) @(posedge clk_i);
      rd(A_ST, q);
      chk("spike_gone", q, 8'h00);
      wr(A_CON, 8'h80);
      rd(A_ADR, q);
      chk("adr_clr", q, 8'h00);
      rd(A_ST, q);
      chk("flags_clr", q, 8'h00);
      wr(A_CON, 8'h00);
      addr(1'b0, 1'b1);
      mst_u.stop();
      $display("test soft reset done");
      end_sim();
   end
endmodule
`default_nettype wire
